// file: hdl/adc_sweep_cfg.sv
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module adc_sweep_cfg (
    input wire logic I_CORE_CLK,
    input wire logic I_SYS_RST,
    input wire logic [3:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    output adc_cfg_pkg::conv_cfg_s O_CFG,
    output logic O_CONV_TICK,
    output logic O_EXT_IN0_EN,
    output logic O_EXT_IN1_EN
);
    logic [7:0] ctrl_one_q;
    logic [7:0] ctrl_two_q;
    logic [7:0] rdata_q;
    adc_cfg_pkg::conv_cfg_s cfg_q;
    adc_cfg_pkg::conv_cfg_s cfg_d;
    logic tick;

    // pins 0 .. n-1 as a mask
    function automatic logic [7:0] low_mask(input logic [3:0] n);
        low_mask = 8'((9'h001 << n) - 9'h001);
    endfunction

    // register writes
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            ctrl_one_q <= adc_cfg_pkg::CONTROL_ONE_RST;
            ctrl_two_q <= adc_cfg_pkg::CONTROL_TWO_RST;
        end else if (I_WR) begin
            if (I_ADDR == adc_cfg_pkg::ADDR_CONTROL_ONE) begin
                ctrl_one_q <= I_WDATA;
            end else if (I_ADDR == adc_cfg_pkg::ADDR_CONTROL_TWO) begin
                ctrl_two_q <= I_WDATA;
            end
        end
    end

    // decode of the mode and sweep fields
    always_comb begin
        logic [1:0] scan;
        logic [1:0] op;
        scan = {ctrl_two_q[adc_cfg_pkg::SWEEP_HI_POS],
                ctrl_two_q[adc_cfg_pkg::SWEEP_LO_POS]};
        op = {ctrl_one_q[adc_cfg_pkg::OP_HI_POS],
              ctrl_one_q[adc_cfg_pkg::OP_LO_POS]};
        cfg_d = '0;
        if (ctrl_two_q[adc_cfg_pkg::SWEEP1_POS]) begin
            cfg_d.mode = adc_cfg_pkg::MODE_SWEEP1;
        end else begin
            case (op)
                2'h0: cfg_d.mode = adc_cfg_pkg::MODE_ONE_SHOT;
                2'h1: cfg_d.mode = adc_cfg_pkg::MODE_REPEAT;
                2'h2: cfg_d.mode = adc_cfg_pkg::MODE_SINGLE_SWEEP;
                default: cfg_d.mode = adc_cfg_pkg::MODE_SWEEP0;
            endcase
        end
        cfg_d.sweep_mask = low_mask({1'b0, scan, 1'b0} + 4'h2);
        cfg_d.focus_mask = low_mask({2'h0, scan} + 4'h1);
        cfg_d.res_ten = ctrl_two_q[adc_cfg_pkg::RES_POS];
        cfg_d.ref_on = ctrl_two_q[adc_cfg_pkg::REF_POS];
        cfg_d.ext_use = {ctrl_two_q[adc_cfg_pkg::AMP_HI_POS],
                         ctrl_two_q[adc_cfg_pkg::AMP_LO_POS]};
    end

    // registered configuration towards the sequencer
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // read data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            rdata_q <= 8'h00;
        end else if (I_RD) begin
            if (I_ADDR == adc_cfg_pkg::ADDR_CONTROL_ONE) begin
                rdata_q <= ctrl_one_q;
            end else if (I_ADDR == adc_cfg_pkg::ADDR_CONTROL_TWO) begin
                rdata_q <= ctrl_two_q;
            end else if (I_ADDR == adc_cfg_pkg::ADDR_STATUS) begin
                rdata_q <= {3'h0, cfg_q.mode};
            end else begin
                rdata_q <= 8'h00;
            end
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // converter clock enable
    adc_clk_div u_div (
        .i_clk(I_CORE_CLK),
        .i_rst(I_SYS_RST),
        .i_full_rate(ctrl_two_q[adc_cfg_pkg::FREQ_HI_POS]),
        .i_half_rate(ctrl_one_q[adc_cfg_pkg::FREQ_LO_POS]),
        .o_tick(tick)
    );

    // extended input use: 00 none, 01 input 0; others held for review
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            O_EXT_IN0_EN <= 1'b0;
            O_EXT_IN1_EN <= 1'b0;
        end else begin
            O_EXT_IN0_EN <= (cfg_d.ext_use == 2'h1);
            O_EXT_IN1_EN <= 1'b0;
        end
    end

    assign O_RDATA = rdata_q;
    assign O_CFG = cfg_q;
    assign O_CONV_TICK = tick;
endmodule // adc_sweep_cfg
`default_nettype wire

// file: hdl/adc_cfg_pkg.sv
package adc_cfg_pkg;
    // register map of the control block
    localparam logic [3:0] ADDR_CONTROL_ONE = 4'h0;
    localparam logic [3:0] ADDR_CONTROL_TWO = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
    localparam logic [7:0] CONTROL_TWO_RST = 8'h00;
    // control-two field positions
    localparam int SWEEP_LO_POS = 0;
    localparam int SWEEP_HI_POS = 1;
    localparam int SWEEP1_POS = 2;
    localparam int RES_POS = 3;
    localparam int FREQ_HI_POS = 4;
    localparam int REF_POS = 5;
    localparam int AMP_LO_POS = 6;
    localparam int AMP_HI_POS = 7;
    // control-one field positions
    localparam int OP_LO_POS = 3;
    localparam int OP_HI_POS = 4;
    localparam int FREQ_LO_POS = 7;
    // divider counts in core clock cycles
    localparam logic [1:0] DIV_TWO_LAST = 2'h1;
    localparam logic [1:0] DIV_FOUR_LAST = 2'h3;

    typedef enum logic [4:0] {
        MODE_ONE_SHOT = 5'h01,
        MODE_REPEAT = 5'h02,
        MODE_SINGLE_SWEEP = 5'h04,
        MODE_SWEEP0 = 5'h08,
        MODE_SWEEP1 = 5'h10
    } conv_mode_e;

    typedef struct packed {
        conv_mode_e mode;
        logic [7:0] sweep_mask;
        logic [7:0] focus_mask;
        logic res_ten;
        logic ref_on;
        logic [1:0] ext_use;
    } conv_cfg_s;
endpackage

// file: hdl/adc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
// converter clock enable: undivided, divided by 2 or by 4
module adc_clk_div (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_full_rate,
    input wire logic i_half_rate,
    output logic o_tick
);
    logic [1:0] cnt_q;
    logic [1:0] last;

    // last count of the current division
    assign last = i_half_rate ? adc_cfg_pkg::DIV_TWO_LAST
                              : adc_cfg_pkg::DIV_FOUR_LAST;

    // free-running counter, restarts on its last value
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= 2'h0;
        end else if (cnt_q >= last) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end

    assign o_tick = i_full_rate | (cnt_q >= last);
endmodule // adc_clk_div
`default_nettype wire

// file: sim/adc_sweep_cfg_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sweep_cfg_asserts (
    input wire logic I_CORE_CLK,
    input wire logic I_SYS_RST,
    input wire logic [3:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] O_RDATA,
    input wire adc_cfg_pkg::conv_cfg_s O_CFG,
    input wire logic O_CONV_TICK,
    input wire logic O_EXT_IN0_EN,
    input wire logic O_EXT_IN1_EN
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_SYS_RST);
    logic [7:0] w_q;
    logic [7:0] ww_q;
    // write data of two edges back
    always_ff @(posedge I_CORE_CLK) begin
        w_q <= I_WDATA;
        ww_q <= w_q;
    end
    // control-two write, decoded two edges later
    sequence wr2;
        I_WR && I_ADDR == 4'h1 ##2 1'b1;
    endsequence
    AST_SWEEP: assert property (wr2 |-> O_CFG.sweep_mask ==
        8'hff >> {~ww_q[1:0], 1'b0}) else $error("sweep mask wrong");
    AST_FOCUS: assert property (wr2 |-> O_CFG.focus_mask ==
        8'h0f >> ~ww_q[1:0]) else $error("focus mask wrong");
    AST_MODE1: assert property (wr2 |-> ww_q[2] ==
        (O_CFG.mode == adc_cfg_pkg::MODE_SWEEP1)) else $error("mode 1 wrong");
    AST_RES: assert property (wr2 |-> O_CFG.res_ten == ww_q[3])
        else $error("resolution wrong");
    AST_REF: assert property (wr2 |-> O_CFG.ref_on == ww_q[5])
        else $error("reference wrong");
    AST_EXT: assert property (wr2 |-> O_EXT_IN0_EN ==
        (ww_q[7:6] == 2'h1) && !O_EXT_IN1_EN) else $error("ext use wrong");
    AST_FULL: assert property (wr2 ##0 ww_q[4] |-> O_CONV_TICK)
        else $error("tick not full rate");
    AST_GAP: assert property ($fell(O_CONV_TICK) |-> ##[1:3] O_CONV_TICK)
        else $error("tick gap too long");
endmodule // adc_sweep_cfg_asserts
bind adc_sweep_cfg adc_sweep_cfg_asserts adc_sweep_cfg_asserts_i (
    .I_CORE_CLK(I_CORE_CLK), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .O_CFG(O_CFG), .O_CONV_TICK(O_CONV_TICK), .O_EXT_IN0_EN(O_EXT_IN0_EN),
    .O_EXT_IN1_EN(O_EXT_IN1_EN));
`default_nettype wire

// file: sim/adc_sweep_cfg_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sweep_cfg_bench;
    logic clk = 0, rst = 1, wr = 0, rd = 0, tick, ex0, ex1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wd = 8'h00, rdata;
    adc_cfg_pkg::conv_cfg_s cfg;
    int n_mismatch = 0, comparisons = 0, cyc = 0, n;
    // rows: control two, sweep mask, focus mask, one-hot mode
    logic [7:0] rows [4][4] = '{'{8'h00, 8'h03, 8'h01, 8'h01},
        '{8'h29, 8'h0f, 8'h03, 8'h01}, '{8'h4e, 8'h3f, 8'h07, 8'h10},
        '{8'hd3, 8'hff, 8'h0f, 8'h01}};
    adc_sweep_cfg adc_sweep_cfg_i (.I_CORE_CLK(clk), .I_SYS_RST(rst),
        .I_ADDR(addr), .I_WDATA(wd), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .O_CFG(cfg), .O_CONV_TICK(tick), .O_EXT_IN0_EN(ex0),
        .O_EXT_IN1_EN(ex1));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task chk(input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wr_t(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 0;
    endtask
    task rd_t(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 chk(rdata, e);
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 0;
        for (int i = 0; i < 4; i++) begin
            wr_t(4'h1, rows[i][0]);
            @(posedge clk);
            #1 chk(cfg.sweep_mask, rows[i][1]);
            chk(cfg.focus_mask, rows[i][2]);
            chk({3'h0, cfg.mode}, rows[i][3]);
            chk({7'h0, cfg.res_ten}, {7'h0, rows[i][0][3]});
            chk({7'h0, cfg.ref_on}, {7'h0, rows[i][0][5]});
            chk({6'h0, ex1, ex0}, {7'h0, rows[i][0][7:6] == 2'h1});
            rd_t(4'h1, rows[i][0]);
        end
        $display("decode rows done");
        for (int m = 0; m < 4; m++) begin
            wr_t(4'h0, 8'(m << 3));
            @(posedge clk);
            #1 chk({3'h0, cfg.mode}, 8'h01 << m);
        end
        wr_t(4'h1, 8'h04);
        @(posedge clk);
        #1 chk({3'h0, cfg.mode}, 8'h10);
        rd_t(4'h2, 8'h10);
        rd_t(4'h0, 8'h18);
        @(posedge clk);
        #1 chk(rdata, 8'h00);
        $display("mode test done");
        for (int k = 0; k < 3; k++) begin
            wr_t(4'h0, k[0] ? 8'h80 : 8'h00);
            wr_t(4'h1, k[1] ? 8'h10 : 8'h00);
            repeat (2) @(posedge clk);
            n = 0;
            repeat (8) begin
                @(posedge clk);
                #1 n += int'(tick);
            end
            chk(8'(n), k[1] ? 8'h08 : k[0] ? 8'h04 : 8'h02);
        end
        $display("divider test done");
        rd_t(4'h9, 8'h00);
        wr_t(4'h1, 8'hff);
        rst <= 1;
        repeat (3) @(posedge clk);
        rst <= 0;
        rd_t(4'h1, 8'h00);
        @(posedge clk);
        #1 chk({3'h0, cfg.mode}, 8'h01);
        $display("reset test done");
        conclude();
    end
endmodule // adc_sweep_cfg_bench
`default_nettype wire
